// file: hw/fbp_protect_ctrl.sv
// APB-reached block-protect checker that grants or refuses program and erase operations
// Function
// - 64-sector part, origin 0: code n of 1..6 guards top 2^(n-1) sectors.
// - 64-sector part, origin 1: code n of 1..6 guards lowest 2^(n-1) sectors.
// - 64-sector part: code 7 guards every sector, origin ignored.
// - All protect bits zero: nothing guarded, both sizes, both origins.
// - 128-sector part, origin 0: code n of 1..7 guards top 2^(n-1) sectors.
// - 128-sector part, origin 1: code n of 1..7 guards lowest 2^(n-1) sectors.
// - 128-sector part: top protect bit set guards every sector.
// - Unguarded sectors are exactly the complement of the guarded range.
// - Origin select zero anchors range at top, one at bottom.
// - Program or sector erase into the guarded range is refused.
// - Whole-array erase accepted only while every protect bit is zero.
`timescale 1ns/1ps
`default_nettype none
module fbp_protect_ctrl (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Operation hand-off to the array engine
   output logic op_go,
   output logic op_refused,
   output logic [1:0] op_kind,
   output logic [6:0] op_sector
);
   fbp_pkg::fbp_cfg_t cfg_reg;
   fbp_pkg::fbp_cfg_t cfg_eff;
   fbp_pkg::fbp_range_t range;
   logic [31:0] prdata_reg;
   logic pready_reg;
   logic pslverr_reg;
   logic op_go_reg;
   logic op_refused_reg;
   logic [1:0] op_kind_reg;
   logic [6:0] op_sector_reg;
   logic done_reg;
   logic accept_reg;
   logic refuse_reg;
   logic setup;
   logic access;
   logic mapped;
   logic writable;
   logic [1:0] req_op;
   logic [6:0] req_sector;
   logic in_range;
   logic beyond_end;
   logic refuse_next;
   logic [31:0] read_word;

   assign setup = psel & ~penable;
   assign access = psel & penable & pready_reg;
   assign mapped = (paddr == fbp_pkg::FBP_CFG_OFS) | (paddr == fbp_pkg::FBP_CMD_OFS)
                 | (paddr == fbp_pkg::FBP_STAT_OFS) | (paddr == fbp_pkg::FBP_RANGE_OFS);
   assign writable = (paddr == fbp_pkg::FBP_CFG_OFS) | (paddr == fbp_pkg::FBP_CMD_OFS);

   // The unused top bit on the small part is masked so every decision agrees
   always_comb
   begin
      cfg_eff = cfg_reg;
      if (!cfg_reg.size_128)
      begin
         cfg_eff.protect_level[3] = 1'b0;
      end
   end

   fbp_range_decode u_decode (
      .cfg(cfg_eff),
      .range(range)
   );

   // Decision made from the config as it stands at the command write
   always_comb
   begin
      req_op = pwdata[fbp_pkg::FBP_CMD_OP_LSB +: 2];
      req_sector = pwdata[fbp_pkg::FBP_CMD_SECTOR_LSB +: 7];
      in_range = range.any_protected & (req_sector >= range.first_sector)
               & (req_sector <= range.last_sector);
      beyond_end = !cfg_eff.size_128 && (req_sector > fbp_pkg::FBP_LAST_SECTOR_64);
      case (req_op)
         fbp_pkg::FBP_OP_PROGRAM: refuse_next = in_range | beyond_end;
         fbp_pkg::FBP_OP_SECTOR_ERASE: refuse_next = in_range | beyond_end;
         fbp_pkg::FBP_OP_BULK_ERASE: refuse_next = (cfg_eff.protect_level != 4'h0);
         default: refuse_next = 1'b1;
      endcase
   end

   always_comb
   begin
      read_word = fbp_pkg::FBP_ZERO_WORD;
      case (paddr)
         fbp_pkg::FBP_CFG_OFS:
         begin
            read_word[fbp_pkg::FBP_CFG_LEVEL_LSB +: 4] = cfg_reg.protect_level;
            read_word[fbp_pkg::FBP_CFG_ORIGIN_BIT] = cfg_reg.region_origin_select;
            read_word[fbp_pkg::FBP_CFG_SIZE_BIT] = cfg_reg.size_128;
         end
         fbp_pkg::FBP_STAT_OFS:
         begin
            read_word[fbp_pkg::FBP_STAT_DONE_BIT] = done_reg;
            read_word[fbp_pkg::FBP_STAT_ACCEPT_BIT] = accept_reg;
            read_word[fbp_pkg::FBP_STAT_REFUSE_BIT] = refuse_reg;
            read_word[fbp_pkg::FBP_STAT_OP_LSB +: 2] = op_kind_reg;
            read_word[fbp_pkg::FBP_STAT_SECTOR_LSB +: 7] = op_sector_reg;
         end
         fbp_pkg::FBP_RANGE_OFS:
         begin
            read_word[fbp_pkg::FBP_RANGE_LO_LSB +: 7] = range.first_sector;
            read_word[fbp_pkg::FBP_RANGE_HI_LSB +: 7] = range.last_sector;
            read_word[fbp_pkg::FBP_RANGE_ANY_BIT] = range.any_protected;
            read_word[fbp_pkg::FBP_RANGE_ALL_BIT] = range.all_protected;
         end
         default: read_word = fbp_pkg::FBP_ZERO_WORD;
      endcase
   end

   // Bus answer: ready in the first cycle of the access phase, data and error registered
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pready_reg <= 1'b0;
         pslverr_reg <= 1'b0;
         prdata_reg <= fbp_pkg::FBP_ZERO_WORD;
      end
      else
      begin
         pready_reg <= setup;
         if (setup)
         begin
            pslverr_reg <= pwrite ? !writable : !mapped;
            prdata_reg <= (pwrite || !mapped) ? fbp_pkg::FBP_ZERO_WORD : read_word;
         end
         else if (access)
         begin
            pslverr_reg <= 1'b0;
            prdata_reg <= fbp_pkg::FBP_ZERO_WORD;
         end
      end
   end

   // Configuration: new protect bits govern every operation after the write
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         cfg_reg <= '0;
      end
      else if (access && pwrite && paddr == fbp_pkg::FBP_CFG_OFS)
      begin
         cfg_reg.protect_level <= pwdata[fbp_pkg::FBP_CFG_LEVEL_LSB +: 4];
         cfg_reg.region_origin_select <= pwdata[fbp_pkg::FBP_CFG_ORIGIN_BIT];
         cfg_reg.size_128 <= pwdata[fbp_pkg::FBP_CFG_SIZE_BIT];
      end
   end

   // Operation launch and its outcome
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         op_go_reg <= 1'b0;
         op_refused_reg <= 1'b0;
         op_kind_reg <= fbp_pkg::FBP_OP_NONE;
         op_sector_reg <= 7'h00;
         done_reg <= 1'b0;
         accept_reg <= 1'b0;
         refuse_reg <= 1'b0;
      end
      else if (access && pwrite && paddr == fbp_pkg::FBP_CMD_OFS)
      begin
         op_go_reg <= !refuse_next;
         op_refused_reg <= refuse_next;
         op_kind_reg <= req_op;
         op_sector_reg <= req_sector;
         done_reg <= 1'b1;
         accept_reg <= !refuse_next;
         refuse_reg <= refuse_next;
      end
      else
      begin
         op_go_reg <= 1'b0;
         op_refused_reg <= 1'b0;
      end
   end

   assign prdata = prdata_reg;
   assign pready = pready_reg;
   assign pslverr = pslverr_reg;
   assign op_go = op_go_reg;
   assign op_refused = op_refused_reg;
   assign op_kind = op_kind_reg;
   assign op_sector = op_sector_reg;
endmodule : fbp_protect_ctrl
`default_nettype wire

// file: hw/fbp_pkg.sv
// Package: register map, field layout and types of the block-protect decoder
package fbp_pkg;
   // Register byte offsets
   localparam logic [7:0] FBP_CFG_OFS = 8'h00;
   localparam logic [7:0] FBP_CMD_OFS = 8'h04;
   localparam logic [7:0] FBP_STAT_OFS = 8'h08;
   localparam logic [7:0] FBP_RANGE_OFS = 8'h0C;
   // Configuration register fields
   localparam int FBP_CFG_LEVEL_LSB = 0;
   localparam int FBP_CFG_ORIGIN_BIT = 4;
   localparam int FBP_CFG_SIZE_BIT = 8;
   // Command register fields
   localparam int FBP_CMD_OP_LSB = 0;
   localparam int FBP_CMD_SECTOR_LSB = 8;
   // Status register fields
   localparam int FBP_STAT_DONE_BIT = 0;
   localparam int FBP_STAT_ACCEPT_BIT = 1;
   localparam int FBP_STAT_REFUSE_BIT = 2;
   localparam int FBP_STAT_OP_LSB = 8;
   localparam int FBP_STAT_SECTOR_LSB = 16;
   // Range register fields
   localparam int FBP_RANGE_LO_LSB = 0;
   localparam int FBP_RANGE_HI_LSB = 8;
   localparam int FBP_RANGE_ANY_BIT = 16;
   localparam int FBP_RANGE_ALL_BIT = 17;
   // Array geometry
   localparam logic [6:0] FBP_LAST_SECTOR_64 = 7'h3F;
   localparam logic [6:0] FBP_LAST_SECTOR_128 = 7'h7F;
   localparam logic [2:0] FBP_CODE_ALL_64 = 3'h7;
   // Operation codes
   localparam logic [1:0] FBP_OP_NONE = 2'h0;
   localparam logic [1:0] FBP_OP_PROGRAM = 2'h1;
   localparam logic [1:0] FBP_OP_SECTOR_ERASE = 2'h2;
   localparam logic [1:0] FBP_OP_BULK_ERASE = 2'h3;
   // Reset values
   localparam logic [31:0] FBP_ZERO_WORD = 32'h0000_0000;

   typedef struct packed {
      logic size_128;
      logic region_origin_select;
      logic [3:0] protect_level;
   } fbp_cfg_t;

   typedef struct packed {
      logic all_protected;
      logic any_protected;
      logic [6:0] last_sector;
      logic [6:0] first_sector;
   } fbp_range_t;
endpackage : fbp_pkg

// file: hw/fbp_range_decode.sv
// Combinational decode of protect code and origin select into a sector range
`timescale 1ns/1ps
`default_nettype none
module fbp_range_decode (
   // Present configuration
   input wire fbp_pkg::fbp_cfg_t cfg,
   // Decoded range
   output var fbp_pkg::fbp_range_t range
);
   logic [6:0] last;
   logic [6:0] count;
   logic [2:0] code;
   logic full;

   always_comb
   begin
      last = cfg.size_128 ? fbp_pkg::FBP_LAST_SECTOR_128 : fbp_pkg::FBP_LAST_SECTOR_64;
      code = cfg.protect_level[2:0];
      // Small part has only three protect bits; the fourth is ignored there
      full = cfg.size_128 ? cfg.protect_level[3]
                          : (code == fbp_pkg::FBP_CODE_ALL_64);
      count = (code == 3'h0) ? 7'h00 : 7'(7'h01 << 3'(code - 3'h1));
      range.all_protected = full;
      range.any_protected = full | (code != 3'h0);
      if (full)
      begin
         range.first_sector = 7'h00;
         range.last_sector = last;
      end
      else if (cfg.region_origin_select)
      begin
         range.first_sector = 7'h00;
         range.last_sector = 7'(count - 7'h01);
      end
      else
      begin
         range.first_sector = 7'(last - count + 7'h01);
         range.last_sector = last;
      end
   end
endmodule : fbp_range_decode
`default_nettype wire

// file: dv/fbp_array_model.sv
// Array engine model that counts the operations let through by the protect check
`timescale 1ns/1ps
`default_nettype none
module fbp_array_model (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Operation hand-off
   input wire logic op_go
);
   int granted;
   // Only work that passed the guard ever reaches the array
   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
         granted <= 0;
      else if (op_go)
         granted <= granted + 1;
endmodule : fbp_array_model
`default_nettype wire

// file: dv/fbp_protect_ctrl_sva.sv
// Assertions on the ports of the block-protect checker
`timescale 1ns/1ps
`default_nettype none
module fbp_protect_ctrl_sva (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // Operation hand-off
   input wire logic op_go,
   input wire logic op_refused,
   input wire logic [1:0] op_kind,
   input wire logic [6:0] op_sector
);
   logic [8:0] cfg_q;
   logic cmd;
   logic eff;
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   assign cmd = psel && penable && pready && pwrite && paddr == fbp_pkg::FBP_CMD_OFS;
   // Bit 3 of the code only counts on the large part
   assign eff = cfg_q[8] ? |cfg_q[3:0] : |cfg_q[2:0];
   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
         cfg_q <= '0;
      else if (psel && penable && pready && pwrite && paddr == fbp_pkg::FBP_CFG_OFS)
         cfg_q <= pwdata[8:0];
   a_ready_access: assert property (psel && !penable |=> pready) else $error("no pready");
   a_ready_single: assert property (pready |=> !pready) else $error("pready too long");
   a_rdata_idle: assert property (!pready |-> prdata == '0) else $error("prdata not idle");
   a_unmapped_err: assert property (pready && paddr > 8'h0C |-> pslverr) else $error("no slverr");
   a_one_answer: assert property (cmd |=> op_go != op_refused) else $error("bad verdict");
   a_pulse_cause: assert property (op_go || op_refused |-> $past(cmd)) else $error("stray pulse");
   a_op_echo: assert property (cmd |=> op_kind == $past(pwdata[1:0])
      && op_sector == $past(pwdata[14:8])) else $error("op echo wrong");
   a_bulk_guard: assert property (cmd && pwdata[1:0] == 2'h3 |=> op_refused == eff)
      else $error("bulk erase verdict wrong");
   a_clear_open: assert property (cmd && !eff && pwdata[1:0] == 2'h1
      && (cfg_q[8] || !pwdata[14]) |=> op_go) else $error("open array refused");
   a_null_refused: assert property (cmd && pwdata[1:0] == 2'h0 |=> op_refused)
      else $error("null op accepted");
endmodule : fbp_protect_ctrl_sva
`default_nettype wire

// file: dv/testbench.sv
// Self-checking bench for the block-protect checker
`timescale 1ns/1ps
`default_nettype none
module testbench;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [31:0] prdata, rd;
   logic pready, pslverr, op_go, op_refused, err;
   logic [1:0] op_kind;
   logic [6:0] op_sector;
   int mismatches = 0;
   int comparisons = 0;
   int oks = 0;
   int n, first, last, cnt, k, s;
   bit big, any, full, refu;
   fbp_protect_ctrl fbp_protect_ctrl_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .op_go(op_go), .op_refused(op_refused),
      .op_kind(op_kind), .op_sector(op_sector));
   fbp_array_model fbp_array_model_inst (.pclk(pclk), .presetn(presetn), .op_go(op_go));
   always #20 pclk = ~pclk;
   task automatic results;
      if (mismatches == 0 && comparisons > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : results
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input logic [31:0] m);
      comparisons++;
      if ((got & m) !== (exp & m))
      begin
         mismatches++;
         $display("[FAIL] %0t got %h want %h", $time, got, exp);
      end
   endtask : chk
   // Idle cycle after each transfer keeps one assignment per signal per edge
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int t;
      t = 0;
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do
      begin
         @(posedge pclk);
         t++;
      end
      while (pready !== 1'b1 && t < 20);
      if (pready !== 1'b1)
      begin
         mismatches++;
         $display("[FAIL] %0t no pready", $time);
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask : apb
   initial
   begin
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, fbp_pkg::FBP_CFG_OFS, 32'h0);
      chk(rd, 32'h0000_0000, 32'hFFFF_FFFF);
      chk({31'b0, err}, 32'h0000_0000, 32'h0000_0001);
      apb(1'b1, fbp_pkg::FBP_STAT_OFS, 32'h0);
      chk({31'b0, err}, 32'h0000_0001, 32'h0000_0001);
      apb(1'b0, 8'h10, 32'h0);
      chk({31'b0, err}, 32'h0000_0001, 32'h0000_0001);
      chk(rd, 32'h0000_0000, 32'hFFFF_FFFF);
      apb(1'b1, fbp_pkg::FBP_CMD_OFS, 32'h0);
      apb(1'b0, fbp_pkg::FBP_STAT_OFS, 32'h0);
      chk(rd, 32'h0000_0005, 32'h0000_0307);
      for (int c = 0; c < 64; c++)
      begin
         big = c[5];
         n = big ? c[3:0] : c[2:0];
         cnt = big ? 128 : 64;
         full = big ? c[3] : n == 7;
         any = n != 0;
         k = full ? cnt : (any ? 1 << (n - 1) : 0);
         first = (c[4] || full) ? 0 : cnt - k;
         last = first + k - 1;
         apb(1'b1, fbp_pkg::FBP_CFG_OFS, {23'b0, c[5], 3'b0, c[4], c[3:0]});
         apb(1'b0, fbp_pkg::FBP_RANGE_OFS, 32'h0);
         chk(rd, {14'b0, full, any, 1'b0, last[6:0], 1'b0, first[6:0]},
            any ? 32'h0003_7F7F : 32'h0003_0000);
         for (int p = 0; p < 6; p++)
         begin
            s = p == 0 ? first - 1 : p == 1 ? first : p == 2 ? last : p == 3 ? last + 1 : p * 25;
            s = s & 127;
            refu = s >= cnt || (any && s >= first && s <= last);
            oks += !refu;
            apb(1'b1, fbp_pkg::FBP_CMD_OFS, {17'b0, s[6:0], 6'b0, 2'(1 + p[0])});
            apb(1'b0, fbp_pkg::FBP_STAT_OFS, 32'h0);
            chk(rd, {9'b0, s[6:0], 6'b0, 2'(1 + p[0]), 5'b0, refu, !refu, 1'b1},
               32'h007F_0307);
         end
         apb(1'b1, fbp_pkg::FBP_CMD_OFS, 32'h3);
         apb(1'b0, fbp_pkg::FBP_STAT_OFS, 32'h0);
         chk(rd, {22'b0, 2'b11, 5'b0, any, !any, 1'b1}, 32'h0000_0307);
         oks += !any;
      end
      chk(fbp_array_model_inst.granted, oks, 32'hFFFF_FFFF);
      // Reset in mid-run must drop the settings and the last verdict
      presetn <= 1'b0;
      @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, fbp_pkg::FBP_STAT_OFS, 32'h0);
      chk(rd, 32'h0000_0000, 32'hFFFF_FFFF);
      apb(1'b0, fbp_pkg::FBP_RANGE_OFS, 32'h0);
      chk(rd, 32'h0000_0000, 32'h0003_0000);
      results();
   end
   initial
   begin
      repeat (20000) @(posedge pclk);
      mismatches++;
      results();
   end
endmodule : testbench
bind fbp_protect_ctrl fbp_protect_ctrl_sva fbp_protect_ctrl_sva_inst (.pclk(pclk),
   .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
   .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .op_go(op_go),
   .op_refused(op_refused), .op_kind(op_kind), .op_sector(op_sector));
`default_nettype wire
